/* hw/clk_switch_pkg.sv */
// shared constants and types for the system clock source switch
package clk_switch_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] OFF_OSC_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_READY_FLAGS = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_TIMER_ONE = 4'h2;
	localparam logic [1:0] SEL_CONFIG = 2'h0;
	localparam logic [1:0] SEL_SECONDARY = 2'h1;
	localparam int SEL_INTERNAL_BIT = 1;
	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_FREQ_LSB = 3;
	localparam int TONE_ENABLE_BIT = 3;
	localparam int FLAG_SEC_READY = 7;
	localparam int FLAG_PLL_READY = 6;
	localparam int FLAG_STARTUP = 5;
	localparam int FLAG_HF_READY = 4;
	localparam int FLAG_HF_LOCKED = 3;
	localparam int FLAG_MF_READY = 2;
	localparam int FLAG_LF_READY = 1;
	localparam int FLAG_HF_STABLE = 0;
	localparam int CLK_HZ = 25000000;
	// stabilisation delays in microseconds, per source kind
	localparam int SETTLE_CONFIG_US = 40;
	localparam int SETTLE_SECONDARY_US = 40;
	localparam int SETTLE_INTERNAL_US = 2;
	localparam int SETTLE_CONFIG_CYC = (SETTLE_CONFIG_US * (CLK_HZ / 1000000) > 0) ?
		SETTLE_CONFIG_US * (CLK_HZ / 1000000) : 1;
	localparam int SETTLE_SECONDARY_CYC = (SETTLE_SECONDARY_US * (CLK_HZ / 1000000) > 0) ?
		SETTLE_SECONDARY_US * (CLK_HZ / 1000000) : 1;
	localparam int SETTLE_INTERNAL_CYC = (SETTLE_INTERNAL_US * (CLK_HZ / 1000000) > 0) ?
		SETTLE_INTERNAL_US * (CLK_HZ / 1000000) : 1;
	localparam int CNT_W = 12;
	typedef enum logic [1:0] {
		SRC_CONFIG,
		SRC_SECONDARY,
		SRC_INTERNAL
	} source_type;
	typedef struct packed {
		logic pll_ready;
		logic hf_ready;
		logic hf_locked;
		logic mf_ready;
		logic lf_ready;
		logic hf_stable;
		logic secondary_ready;
		logic crystal_timer_done;
		logic fail_safe_active;
	} osc_status_type;
endpackage

/* hw/clk_switch.sv */
// system clock source switch with oscillator status register
`timescale 1ns/10ps
module clk_switch (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [3:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	input wire logic [2:0] CONFIG_OSC_SEL,
	input wire logic CONFIG_IS_CRYSTAL,
	input wire clk_switch_pkg::osc_status_type OSC_STATUS,
	output logic [1:0] SYSCLK_SOURCE,
	output logic [3:0] SYSCLK_FREQ,
	output logic [2:0] SYSCLK_CONFIG_SEL,
	output logic SECONDARY_OSC_RUN
);
	logic [7:0] status_s1_ff;
	logic [7:0] status_s2_ff;
	logic [2:0] cfg_s1_ff;
	logic [2:0] cfg_s2_ff;
	logic xtal_s1_ff;
	logic xtal_s2_ff;
	logic [1:0] sel_ff;
	logic [3:0] freq_ff;
	logic [7:0] tone_ctrl_ff;
	clk_switch_pkg::source_type active_ff;
	clk_switch_pkg::source_type pending_ff;
	clk_switch_pkg::source_type target;
	logic [clk_switch_pkg::CNT_W-1:0] settle_ff;
	logic startup_ff;
	logic [1:0] src_out_ff;
	logic [3:0] freq_out_ff;
	logic [2:0] cfg_out_ff;
	logic sec_run_ff;
	logic [7:0] rdata_ff;
	logic [7:0] flags_view;
	logic sec_ready;
	logic crystal_done;
	logic fail_safe;

	function automatic clk_switch_pkg::source_type decode_sel(input logic [1:0] sel);
		clk_switch_pkg::source_type s;
		s = clk_switch_pkg::SRC_CONFIG;
		if (sel[clk_switch_pkg::SEL_INTERNAL_BIT])
			s = clk_switch_pkg::SRC_INTERNAL;
		else if (sel == clk_switch_pkg::SEL_SECONDARY)
			s = clk_switch_pkg::SRC_SECONDARY;
		return s;
	endfunction

	function automatic logic [clk_switch_pkg::CNT_W-1:0] settle_of(input clk_switch_pkg::source_type s);
		logic [clk_switch_pkg::CNT_W-1:0] c;
		c = clk_switch_pkg::CNT_W'(clk_switch_pkg::SETTLE_INTERNAL_CYC);
		case (s)
			clk_switch_pkg::SRC_CONFIG: c = clk_switch_pkg::CNT_W'(clk_switch_pkg::SETTLE_CONFIG_CYC);
			clk_switch_pkg::SRC_SECONDARY: c = clk_switch_pkg::CNT_W'(clk_switch_pkg::SETTLE_SECONDARY_CYC);
			default: c = clk_switch_pkg::CNT_W'(clk_switch_pkg::SETTLE_INTERNAL_CYC);
		endcase
		return c;
	endfunction

	// oscillator flags come from other clock domains
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			status_s1_ff <= 8'h00;
			status_s2_ff <= 8'h00;
			cfg_s1_ff <= 3'h0;
			cfg_s2_ff <= 3'h0;
			xtal_s1_ff <= 1'b0;
			xtal_s2_ff <= 1'b0;
		end else begin
			// same bit order as the flags register
			status_s1_ff <= {OSC_STATUS.secondary_ready, OSC_STATUS.pll_ready, OSC_STATUS.crystal_timer_done,
				OSC_STATUS.hf_ready, OSC_STATUS.hf_locked, OSC_STATUS.mf_ready,
				OSC_STATUS.lf_ready, OSC_STATUS.hf_stable};
			status_s2_ff <= status_s1_ff;
			cfg_s1_ff <= CONFIG_OSC_SEL;
			cfg_s2_ff <= cfg_s1_ff;
			xtal_s1_ff <= CONFIG_IS_CRYSTAL;
			xtal_s2_ff <= xtal_s1_ff;
		end
	end

	logic fs_s1_ff;
	logic fs_s2_ff;
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			fs_s1_ff <= 1'b0;
			fs_s2_ff <= 1'b0;
		end else begin
			fs_s1_ff <= OSC_STATUS.fail_safe_active;
			fs_s2_ff <= fs_s1_ff;
		end
	end

	assign sec_ready = status_s2_ff[clk_switch_pkg::FLAG_SEC_READY] & tone_ctrl_ff[clk_switch_pkg::TONE_ENABLE_BIT];
	assign crystal_done = status_s2_ff[clk_switch_pkg::FLAG_STARTUP];
	assign fail_safe = fs_s2_ff;

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sel_ff <= clk_switch_pkg::SEL_CONFIG;
			freq_ff <= 4'h0;
		end else if (REG_WR && REG_ADDR == clk_switch_pkg::OFF_OSC_CTRL) begin
			sel_ff <= REG_WDATA[clk_switch_pkg::CTRL_SEL_LSB +: 2];
			freq_ff <= REG_WDATA[clk_switch_pkg::CTRL_FREQ_LSB +: 4];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			tone_ctrl_ff <= 8'h00;
		else if (REG_WR && REG_ADDR == clk_switch_pkg::OFF_TIMER_ONE)
			tone_ctrl_ff <= REG_WDATA;
	end

	always_comb begin
		target = decode_sel(sel_ff);
		if (fail_safe)
			target = clk_switch_pkg::SRC_INTERNAL;
		else if (target == clk_switch_pkg::SRC_CONFIG && xtal_s2_ff && !crystal_done)
			target = clk_switch_pkg::SRC_INTERNAL;
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			active_ff <= clk_switch_pkg::SRC_INTERNAL;
			pending_ff <= clk_switch_pkg::SRC_INTERNAL;
			settle_ff <= '0;
		end else if (target == active_ff) begin
			pending_ff <= target;
			settle_ff <= '0;
		end else if (target != pending_ff) begin
			// a changed choice mid-count restarts the full delay
			pending_ff <= target;
			settle_ff <= '0;
		end else if (settle_ff >= settle_of(target) - clk_switch_pkg::CNT_W'(1)) begin
			active_ff <= target;
			settle_ff <= '0;
		end else begin
			settle_ff <= settle_ff + clk_switch_pkg::CNT_W'(1);
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			startup_ff <= 1'b0;
		else
			startup_ff <= (active_ff == clk_switch_pkg::SRC_CONFIG);
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			src_out_ff <= 2'h0;
			freq_out_ff <= 4'h0;
			cfg_out_ff <= 3'h0;
			sec_run_ff <= 1'b0;
		end else begin
			case (active_ff)
				clk_switch_pkg::SRC_CONFIG: src_out_ff <= 2'h0;
				clk_switch_pkg::SRC_SECONDARY: src_out_ff <= 2'h1;
				clk_switch_pkg::SRC_INTERNAL: src_out_ff <= 2'h2;
				default: src_out_ff <= 2'h2;
			endcase
			freq_out_ff <= freq_ff;
			cfg_out_ff <= cfg_s2_ff;
			sec_run_ff <= tone_ctrl_ff[clk_switch_pkg::TONE_ENABLE_BIT];
		end
	end

	always_comb begin
		flags_view = status_s2_ff;
		flags_view[clk_switch_pkg::FLAG_SEC_READY] = sec_ready;
		flags_view[clk_switch_pkg::FLAG_STARTUP] = startup_ff;
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_ff <= 8'h00;
		end else if (REG_RD) begin
			case (REG_ADDR)
				clk_switch_pkg::OFF_OSC_CTRL: rdata_ff <= {1'b0, freq_ff, 1'b0, sel_ff};
				clk_switch_pkg::OFF_READY_FLAGS: rdata_ff <= flags_view;
				clk_switch_pkg::OFF_TIMER_ONE: rdata_ff <= tone_ctrl_ff;
				default: rdata_ff <= 8'h00;
			endcase
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	assign REG_RDATA = rdata_ff;
	assign SYSCLK_SOURCE = src_out_ff;
	assign SYSCLK_FREQ = freq_out_ff;
	assign SYSCLK_CONFIG_SEL = cfg_out_ff;
	assign SECONDARY_OSC_RUN = sec_run_ff;

	property p_sel_reset;
		@(posedge SYS_CLK) $rose(RST_N) |-> sel_ff == clk_switch_pkg::SEL_CONFIG;
	endproperty
	a_sel_reset: assert property (p_sel_reset) else $error("select not cleared by reset");

	property p_fs_keeps_sel;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(fail_safe && !REG_WR) |=> sel_ff == $past(sel_ff);
	endproperty
	a_fs_keeps_sel: assert property (p_fs_keeps_sel) else $error("automatic switch changed select");

	property p_startup_flag;
		@(posedge SYS_CLK) disable iff (!RST_N)
		1'b1 |=> startup_ff == ($past(active_ff) == clk_switch_pkg::SRC_CONFIG);
	endproperty
	a_startup_flag: assert property (p_startup_flag) else $error("timeout status wrong");

	property p_settle;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(active_ff != $past(active_ff)) |-> $past(settle_ff) == settle_of(active_ff) - clk_switch_pkg::CNT_W'(1);
	endproperty
	a_settle: assert property (p_settle) else $error("switched before delay");

	property p_xtal_timer;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(xtal_s2_ff && !crystal_done && !fail_safe) |=> active_ff != clk_switch_pkg::SRC_CONFIG ||
			$past(active_ff) == clk_switch_pkg::SRC_CONFIG;
	endproperty
	a_xtal_timer: assert property (p_xtal_timer) else $error("crystal used before timer");

	property p_sec_run;
		@(posedge SYS_CLK) disable iff (!RST_N)
		1'b1 |=> SECONDARY_OSC_RUN == $past(tone_ctrl_ff[clk_switch_pkg::TONE_ENABLE_BIT]);
	endproperty
	a_sec_run: assert property (p_sec_run) else $error("secondary run not tied to enable");

	property p_src_out;
		@(posedge SYS_CLK) disable iff (!RST_N)
		$past(active_ff) == clk_switch_pkg::SRC_SECONDARY |-> SYSCLK_SOURCE == 2'h1;
	endproperty
	a_src_out: assert property (p_src_out) else $error("clock output not secondary");

	property p_rd_gap;
		@(posedge SYS_CLK) disable iff (!RST_N)
		!$past(REG_RD) |-> REG_RDATA == 8'h00;
	endproperty
	a_rd_gap: assert property (p_rd_gap) else $error("read data outside read slot");

	property p_sel_write;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(REG_WR && REG_ADDR == clk_switch_pkg::OFF_OSC_CTRL) |=>
			sel_ff == $past(REG_WDATA[clk_switch_pkg::CTRL_SEL_LSB +: 2]);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("select write lost");

	property p_cfg_src;
		@(posedge SYS_CLK) disable iff (!RST_N)
		$past(active_ff) == clk_switch_pkg::SRC_CONFIG |-> SYSCLK_SOURCE == clk_switch_pkg::SEL_CONFIG;
	endproperty
	a_cfg_src: assert property (p_cfg_src) else $error("clock output not configured source");

	property p_cfg_bits;
		@(posedge SYS_CLK) disable iff (!RST_N)
		1'b1 |=> SYSCLK_CONFIG_SEL == $past(cfg_s2_ff);
	endproperty
	a_cfg_bits: assert property (p_cfg_bits) else $error("configuration bits not passed on");

	property p_sec_target;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(!fail_safe && sel_ff == clk_switch_pkg::SEL_SECONDARY) |-> target == clk_switch_pkg::SRC_SECONDARY;
	endproperty
	a_sec_target: assert property (p_sec_target) else $error("select 01 not secondary");

	property p_int_target;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(!fail_safe && sel_ff[clk_switch_pkg::SEL_INTERNAL_BIT]) |-> target == clk_switch_pkg::SRC_INTERNAL;
	endproperty
	a_int_target: assert property (p_int_target) else $error("select 1x not internal");

	property p_int_freq;
		@(posedge SYS_CLK) disable iff (!RST_N)
		1'b1 |=> SYSCLK_FREQ == $past(freq_ff);
	endproperty
	a_int_freq: assert property (p_int_freq) else $error("internal frequency not passed on");

	property p_fs_internal;
		@(posedge SYS_CLK) disable iff (!RST_N)
		fail_safe |-> target == clk_switch_pkg::SRC_INTERNAL;
	endproperty
	a_fs_internal: assert property (p_fs_internal) else $error("fail safe not internal");

	property p_new_target;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(target != active_ff && target != pending_ff) |=> active_ff == $past(active_ff);
	endproperty
	a_new_target: assert property (p_new_target) else $error("switched without delay");

	property p_idle_count;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(target == active_ff) |=> settle_ff == '0;
	endproperty
	a_idle_count: assert property (p_idle_count) else $error("settle count not cleared");

	property p_sec_no_status;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(active_ff == clk_switch_pkg::SRC_SECONDARY) |=> !startup_ff;
	endproperty
	a_sec_no_status: assert property (p_sec_no_status) else $error("timeout status tracks secondary");

	property p_sec_ready_gate;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(REG_RD && REG_ADDR == clk_switch_pkg::OFF_READY_FLAGS && !tone_ctrl_ff[clk_switch_pkg::TONE_ENABLE_BIT]) |=>
			!REG_RDATA[clk_switch_pkg::FLAG_SEC_READY];
	endproperty
	a_sec_ready_gate: assert property (p_sec_ready_gate) else $error("secondary ready while disabled");

	property p_flags_read;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(REG_RD && REG_ADDR == clk_switch_pkg::OFF_READY_FLAGS) |=>
			REG_RDATA[clk_switch_pkg::FLAG_PLL_READY] == $past(status_s2_ff[clk_switch_pkg::FLAG_PLL_READY]) &&
			REG_RDATA[clk_switch_pkg::FLAG_STARTUP] == $past(startup_ff);
	endproperty
	a_flags_read: assert property (p_flags_read) else $error("flags read not live");

	property p_flags_nowrite;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(REG_WR && REG_ADDR == clk_switch_pkg::OFF_READY_FLAGS) |=>
			sel_ff == $past(sel_ff) && tone_ctrl_ff == $past(tone_ctrl_ff);
	endproperty
	a_flags_nowrite: assert property (p_flags_nowrite) else $error("flags write had effect");
endmodule // clk_switch

/* tb/system_clock_source_switch_bench.sv */
// self-checking bench for the system clock source switch
`timescale 1ns/10ps
module system_clock_source_switch_bench;
	logic sys_clk, rst_n, reg_wr, reg_rd, cfg_crystal, sec_run;
	logic [3:0] reg_addr, sys_freq, f;
	logic [7:0] reg_wdata, reg_rdata, rd;
	logic [8:0] r;
	logic [2:0] cfg_sel, cfg_out;
	logic [1:0] src, old;
	clk_switch_pkg::osc_status_type osc;
	int miscompares, compares;
	integer seed;

	clk_switch uut (.SYS_CLK(sys_clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CONFIG_OSC_SEL(cfg_sel),
		.CONFIG_IS_CRYSTAL(cfg_crystal), .OSC_STATUS(osc), .SYSCLK_SOURCE(src), .SYSCLK_FREQ(sys_freq),
		.SYSCLK_CONFIG_SEL(cfg_out), .SECONDARY_OSC_RUN(sec_run));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// live flags as software should see them
	function automatic logic [7:0] flags_exp(input clk_switch_pkg::osc_status_type s, input logic en, input logic st);
		return {s.secondary_ready & en, s.pll_ready, st, s.hf_ready, s.hf_locked, s.mf_ready, s.lf_ready, s.hf_stable};
	endfunction

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe
	task automatic rdreg(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		seed = 95;
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		cfg_crystal = 1'b0;
		osc = '0;
		cfg_sel = 3'($random(seed));
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		rdreg(clk_switch_pkg::OFF_OSC_CTRL, rd);
		chk(rd, 8'h00, "select after reset");
		rdreg(clk_switch_pkg::OFF_TIMER_ONE, rd);
		chk(rd, 8'h00, "timer one after reset");
		rdreg(4'hF, rd);
		chk(rd, 8'h00, "unmapped read");
		wait_cyc(1100);
		chk({6'h00, src}, 8'h00, "config source");
		chk({5'h00, cfg_out}, {5'h00, cfg_sel}, "config bits");
		rdreg(clk_switch_pkg::OFF_READY_FLAGS, rd);
		chk({7'h00, rd[5]}, 8'h01, "status on config");
		$display("test reset and config done");
		for (int i = 0; i < 4; i++) begin
			f = 4'($random(seed));
			r = 9'($random(seed));
			old = src;
			osc <= {r[8:3], 3'b000};
			// both internal codes 10 and 11 get used
			wr(clk_switch_pkg::OFF_OSC_CTRL, {1'b0, f, 2'b01, i[0]});
			wait_cyc(10);
			chk({6'h00, src}, {6'h00, old}, "source before settle");
			wait_cyc(60);
			chk({6'h00, src}, 8'h02, "internal source");
			chk({4'h0, sys_freq}, {4'h0, f}, "internal freq");
			rdreg(clk_switch_pkg::OFF_OSC_CTRL, rd);
			chk(rd, {1'b0, f, 2'b01, i[0]}, "control readback");
			wr(clk_switch_pkg::OFF_READY_FLAGS, 8'($random(seed)));
			rdreg(clk_switch_pkg::OFF_READY_FLAGS, rd);
			chk(rd, flags_exp(osc, 1'b0, 1'b0), "flags read only");
		end
		$display("test internal and flags done");
		wr(clk_switch_pkg::OFF_TIMER_ONE, 8'h08);
		wait_cyc(4);
		chk({7'h00, sec_run}, 8'h01, "secondary enabled");
		osc.secondary_ready <= 1'b1;
		wait_cyc(4);
		rdreg(clk_switch_pkg::OFF_READY_FLAGS, rd);
		chk(rd, flags_exp(osc, 1'b1, 1'b0), "secondary ready flag");
		wr(clk_switch_pkg::OFF_OSC_CTRL, 8'h01);
		wait_cyc(1100);
		chk({6'h00, src}, 8'h01, "secondary source");
		wr(clk_switch_pkg::OFF_OSC_CTRL, 8'h00);
		wait_cyc(1100);
		chk({6'h00, src}, 8'h00, "back to config");
		wr(clk_switch_pkg::OFF_TIMER_ONE, 8'h00);
		wait_cyc(4);
		chk({7'h00, sec_run}, 8'h00, "secondary stopped");
		rdreg(clk_switch_pkg::OFF_READY_FLAGS, rd);
		chk({7'h00, rd[7]}, 8'h00, "ready gated by enable");
		$display("test secondary done");
		osc.fail_safe_active <= 1'b1;
		wait_cyc(100);
		chk({6'h00, src}, 8'h02, "fail safe internal");
		rdreg(clk_switch_pkg::OFF_OSC_CTRL, rd);
		chk(rd, 8'h00, "select untouched");
		rdreg(clk_switch_pkg::OFF_READY_FLAGS, rd);
		chk({7'h00, rd[5]}, 8'h00, "status on internal");
		osc.fail_safe_active <= 1'b0;
		cfg_crystal <= 1'b1;
		wait_cyc(1100);
		chk({6'h00, src}, 8'h02, "crystal timer pending");
		osc.crystal_timer_done <= 1'b1;
		wait_cyc(1100);
		chk({6'h00, src}, 8'h00, "crystal timer expired");
		rdreg(clk_switch_pkg::OFF_READY_FLAGS, rd);
		chk({7'h00, rd[5]}, 8'h01, "status after timer");
		$display("test fail safe and crystal done");
		// a second reset in mid-run must drop the select again
		wr(clk_switch_pkg::OFF_OSC_CTRL, 8'h02);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rdreg(clk_switch_pkg::OFF_OSC_CTRL, rd);
		chk(rd, 8'h00, "select after second reset");
		chk({4'h0, sys_freq}, 8'h00, "freq after second reset");
		$display("test second reset done");
		end_sim();
	end

	// run needs about 6000 cycles
	initial begin
		#(20000 * 40);
		miscompares++;
		$display("mismatch at %0t: watchdog expired", $time);
		end_sim();
	end
endmodule // system_clock_source_switch_bench
